// File: rt_ops_pkg.sv
// Package for the sequencer run-time operation unit.
// Assumes one 50 MHz clock; every figure below is used by the unit or feeds one that is.
package rt_ops_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int SEQ_CYCLE_NS    = 4;
    localparam int WAIT_OVERHEAD   = 2;
    localparam int WAIT_MIN_CYC    = 3;
    localparam int BUS_RATE_MHZ    = 50;
    localparam int BUS_GAP_CYC     = (1000 / BUS_RATE_MHZ) / CLK_PERIOD_NS;
    localparam int SAMPLE_RATE_MSA = 2000;
    // Samples per clock at the full sample rate
    localparam int SAMP_PER_CLK    =
        (SAMPLE_RATE_MSA * CLK_PERIOD_NS) / 1000;
    localparam int ZERO_MIN_SAMP   = 32;
    localparam int ZERO_STEP_SAMP  = 16;

    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [1:0]  TRIG_RST = 2'h0;

    // Operation codes
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_ADD        = 4'h1,
        OP_SUB        = 4'h2,
        OP_LOAD       = 4'h3,
        OP_PIO_WR     = 4'h4,
        OP_PIO_RD     = 4'h5,
        OP_PIO_LRD    = 4'h6,
        OP_TRIG_OUT   = 4'h7,
        OP_WAIT       = 4'h8,
        OP_STROBE_WT  = 4'h9,
        OP_TIN_POLL   = 4'hA,
        OP_TIN_WAIT   = 4'hB,
        OP_HREG_WR    = 4'hC,
        OP_HREG_RD    = 4'hD,
        OP_SPACING    = 4'hE,
        OP_OSC        = 4'hF
    } op_e;

    // Oscillator sub-operations carried in rate field, low two bits
    localparam logic [1:0] OSC_SWEEP_SETUP = 2'h0;
    localparam logic [1:0] OSC_SWEEP_STEP  = 2'h1;
    localparam logic [1:0] OSC_PHASE_ZERO  = 2'h2;
    localparam logic [1:0] OSC_LAUNCH      = 2'h3;

    // One issued instruction
    typedef struct packed {
        op_e         op;
        logic [3:0]  dst;     // Variable written
        logic [3:0]  src;     // Variable read
        logic        use_imm; // Operand from imm, else from variable
        logic [3:0]  sel;     // Register / trigger / oscillator index
        logic [3:0]  rate;    // Spacing rate exponent
        logic [31:0] imm;
        logic [31:0] imm2;    // Sweep increment
    } instr_s;

    // Oscillator command towards the oscillator block
    typedef struct packed {
        logic        setup;
        logic        step;
        logic        phase_zero;
        logic [3:0]  osc;
        logic [31:0] start_hz;
        logic [31:0] inc_hz;
        logic [31:0] index;
    } osc_cmd_s;

    // Condition test of a numeric value
    function automatic logic is_true(input logic [31:0] v);
        return v != 32'h0000_0000;
    endfunction : is_true

endpackage : rt_ops_pkg

// File: readout_sequencer_runtime_ops.sv
// Run-time operation unit of a readout sequencer: variables, parallel
// port, trigger lines, waits, host registers, spacing and oscillators.
// Assumes instructions arrive one at a time on a valid/ready pair and all
// inputs are synchronous to clock.
`timescale 1ns/1ps
module readout_sequencer_runtime_ops
    import rt_ops_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // Instruction stream
    input  wire instr_s      instr,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    // Parallel I/O bus and its strobe configuration
    input  wire logic [31:0] parallel_io_bus_in,
    output logic [31:0]      parallel_io_bus_out,
    input  wire logic [4:0]  strobe_index,
    input  wire logic        strobe_rising,
    // Trigger lines
    output logic [1:0]       trig_out,
    input  wire logic [1:0]  trig_in,
    // Host register port
    input  wire logic [3:0]  host_addr,
    input  wire logic [31:0] host_wdata,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    output logic [31:0]      host_rdata,
    // Oscillator and readout side
    output osc_cmd_s         osc_cmd,
    output logic             readout_launch,
    output logic             spacing_busy,
    output logic             cond_true
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BLOCK = 2'b11
    } state_e;

    // State
    state_e       state_r;
    logic [31:0]  vars_r [16];
    logic [31:0]  ureg_r [16];
    logic [31:0]  latched_r;
    logic         strobe_prev_r;
    logic [1:0]   trig_prev_r;
    logic [31:0]  wait_cnt_r;
    logic [31:0]  space_cnt_r;
    logic [3:0]   bus_gap_r;
    logic [31:0]  pio_out_r;
    logic [1:0]   trig_out_r;
    logic [31:0]  host_rdata_r;
    osc_cmd_s     osc_cmd_r;
    logic         launch_r;
    logic         cond_r;
    instr_s       cur_r;

    // Operand select and strobe decode
    wire  [31:0]  operand     = instr.use_imm ? instr.imm : vars_r[instr.src];
    wire  [31:0]  dst_val     = vars_r[instr.dst];
    wire          strobe_now  = parallel_io_bus_in[strobe_index];
    wire          strobe_edge = strobe_rising ?
                                (strobe_now & ~strobe_prev_r) :
                                (~strobe_now & strobe_prev_r);
    wire  [1:0]   trig_rise   = trig_in & ~trig_prev_r;
    wire          tin_idx     = instr.sel[1];                     // 1->0,2->1
    wire  [31:0]  poll_word   = {31'h0, trig_in[tin_idx]};
    wire          cur_idx     = cur_r.sel[1];
    wire          take        = instr_valid & instr_ready & clk_en;

    // Wait length: requested plus overhead, floored at the minimum
    wire  [31:0]  wait_total  = operand + 32'(WAIT_OVERHEAD);
    wire  [31:0]  wait_len    = (wait_total < 32'(WAIT_MIN_CYC)) ?
                                32'(WAIT_MIN_CYC) : wait_total;
    // Wait counted in clock ticks; sequencer cycles are 4 ns each
    wire  [31:0]  wait_ticks  = (wait_len * 32'(SEQ_CYCLE_NS)
                                + 32'(CLK_PERIOD_NS - 1))
                                / 32'(CLK_PERIOD_NS);

    // Spacing: clamp to minimum, round up to step, scale by rate
    wire  [31:0]  sp_min      = (operand < 32'(ZERO_MIN_SAMP)) ?
                                32'(ZERO_MIN_SAMP) : operand;
    wire  [31:0]  sp_step     = (sp_min + 32'(ZERO_STEP_SAMP - 1))
                                & ~32'(ZERO_STEP_SAMP - 1);
    wire  [31:0]  sp_scaled   = sp_step << instr.rate;
    wire  [31:0]  sp_ticks    = (sp_scaled + 32'(SAMP_PER_CLK - 1))
                                / 32'(SAMP_PER_CLK);

    // Blocking conditions checked before taking an instruction
    wire          pio_block   = (instr.op == OP_PIO_WR) && (bus_gap_r != 0);
    wire          sp_block    = (instr.op == OP_SPACING) && spacing_busy;
    assign instr_ready = (state_r == ST_IDLE)
                       & ~pio_block & ~sp_block;
    assign spacing_busy = (space_cnt_r != 32'h0000_0000);

    // Outputs from flip-flops
    assign parallel_io_bus_out = pio_out_r;
    assign trig_out            = trig_out_r;
    assign host_rdata          = host_rdata_r;
    assign osc_cmd             = osc_cmd_r;
    assign readout_launch      = launch_r;
    assign cond_true           = cond_r;

    // Sequencer state machine; blocking ops park here until they clear
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else if (clk_en) begin
            case (state_r)
                ST_IDLE: begin
                    if (take && instr.op == OP_WAIT) begin
                        state_r <= ST_WAIT;
                    end else if (take && (instr.op == OP_STROBE_WT ||
                                          instr.op == OP_TIN_WAIT)) begin
                        state_r <= ST_BLOCK;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt_r <= 32'h0000_0001) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_BLOCK: begin
                    if (cur_r.op == OP_STROBE_WT && strobe_edge) begin
                        state_r <= ST_IDLE;
                    end else if (cur_r.op == OP_TIN_WAIT &&
                                 trig_rise[cur_idx]) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Counters: wait length, spacing length, bus update gap
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_cnt_r  <= WORD_RST;
            space_cnt_r <= WORD_RST;
            bus_gap_r   <= 4'h0;
            cur_r       <= '0;
        end else if (clk_en) begin
            if (take) begin
                cur_r <= instr;
            end
            if (take && instr.op == OP_WAIT) begin
                wait_cnt_r <= wait_ticks;
            end else if (wait_cnt_r != 32'h0000_0000) begin
                wait_cnt_r <= wait_cnt_r - 32'h0000_0001;
            end
            if (take && instr.op == OP_SPACING) begin
                space_cnt_r <= sp_ticks;
            end else if (spacing_busy) begin
                space_cnt_r <= space_cnt_r - 32'h0000_0001;
            end
            if (take && instr.op == OP_PIO_WR) begin
                bus_gap_r <= 4'(BUS_GAP_CYC - 1);
            end else if (bus_gap_r != 4'h0) begin
                bus_gap_r <= bus_gap_r - 4'h1;
            end
        end
    end

    // Edge history of the strobe bit and trigger inputs
    always_ff @(posedge clock) begin
        if (reset) begin
            strobe_prev_r <= 1'b0;
            trig_prev_r   <= TRIG_RST;
            latched_r     <= WORD_RST;
        end else if (clk_en) begin
            strobe_prev_r <= strobe_now;
            trig_prev_r   <= trig_in;
            if (strobe_edge) begin
                latched_r <= parallel_io_bus_in;
            end
        end
    end

    // Variable file: integer add and subtract only, plus loads
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                vars_r[i] <= WORD_RST;
            end
        end else if (take) begin
            case (instr.op)
                OP_ADD:      vars_r[instr.dst] <= dst_val + operand;
                OP_SUB:      vars_r[instr.dst] <= dst_val - operand;
                OP_LOAD:     vars_r[instr.dst] <= operand;
                OP_PIO_RD:   vars_r[instr.dst] <= parallel_io_bus_in;
                OP_PIO_LRD:  vars_r[instr.dst] <= latched_r;
                OP_TIN_POLL: vars_r[instr.dst] <= poll_word;
                OP_HREG_RD:  vars_r[instr.dst] <= ureg_r[instr.sel];
                default:     ;
            endcase
        end
    end

    // User registers: sequencer write wins over a same-cycle host write
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                ureg_r[i] <= WORD_RST;
            end
            host_rdata_r <= WORD_RST;
        end else if (clk_en) begin
            if (take && instr.op == OP_HREG_WR) begin
                ureg_r[instr.sel] <= operand;
            end else if (host_wr) begin
                ureg_r[host_addr] <= host_wdata;
            end
            host_rdata_r <= host_rd ? ureg_r[host_addr] : WORD_RST;
        end
    end

    // Port and trigger outputs, condition flag
    always_ff @(posedge clock) begin
        if (reset) begin
            pio_out_r  <= WORD_RST;
            trig_out_r <= TRIG_RST;
            cond_r     <= 1'b0;
        end else if (take) begin
            cond_r <= is_true(operand);
            if (instr.op == OP_PIO_WR) begin
                pio_out_r <= operand;
            end
            if (instr.op == OP_TRIG_OUT) begin
                trig_out_r <= operand[1:0];
            end
        end
    end

    // Oscillator commands and readout launch, one-cycle pulses
    always_ff @(posedge clock) begin
        if (reset) begin
            osc_cmd_r <= '0;
            launch_r  <= 1'b0;
        end else if (clk_en) begin
            osc_cmd_r.setup      <= 1'b0;
            osc_cmd_r.step       <= 1'b0;
            osc_cmd_r.phase_zero <= 1'b0;
            launch_r             <= 1'b0;
            if (take && instr.op == OP_OSC) begin
                osc_cmd_r.osc <= instr.sel;
                case (instr.rate[1:0])
                    OSC_SWEEP_SETUP: begin
                        osc_cmd_r.setup    <= 1'b1;
                        osc_cmd_r.start_hz <= instr.imm;
                        osc_cmd_r.inc_hz   <= instr.imm2;
                    end
                    OSC_SWEEP_STEP: begin
                        osc_cmd_r.step  <= 1'b1;
                        osc_cmd_r.index <= vars_r[instr.src];
                    end
                    OSC_PHASE_ZERO: begin
                        osc_cmd_r.phase_zero <= 1'b1;
                    end
                    default: begin
                        launch_r <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : readout_sequencer_runtime_ops

// File: rt_ops_assertions.sv
// Port-level checker for the run-time operation unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rt_ops_checker
    import rt_ops_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // Instruction stream
    input wire logic        clk_en,
    input wire instr_s      instr,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    // Watched outputs
    input wire logic [31:0] parallel_io_bus_out,
    input wire logic [1:0]  trig_out,
    input wire logic        host_rd,
    input wire logic [31:0] host_rdata,
    input wire logic        readout_launch,
    input wire logic        spacing_busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Accepted instruction, decoded once
    wire take = instr_valid & instr_ready & clk_en;
    wire imm  = take & instr.use_imm;
    wire wr   = take & (instr.op == OP_PIO_WR);

    AST_TRIG_BITS: assert property (
        imm && instr.op == OP_TRIG_OUT |=> trig_out == $past(instr.imm[1:0]))
        else $error("trigger outputs differ from operand bits");
    AST_PIO_WORD: assert property (
        imm && wr |=> parallel_io_bus_out == $past(instr.imm))
        else $error("port output differs from written word");
    // Only a port write may move the bus, so no faster than one per clock
    AST_PIO_CAUSE: assert property (
        $changed(parallel_io_bus_out) |-> $past(wr))
        else $error("port output changed without a write");
    AST_WAIT_STALL: assert property (
        take && instr.op == OP_WAIT |=> !instr_ready)
        else $error("wait did not stall");
    AST_SPACE_BUSY: assert property (
        take && instr.op == OP_SPACING |=> spacing_busy)
        else $error("spacing did not start");
    AST_SPACE_HOLD: assert property (
        spacing_busy && instr_valid && instr.op == OP_SPACING |-> !instr_ready)
        else $error("spacing accepted while busy");
    AST_HOST_IDLE: assert property (
        !$past(host_rd) |-> host_rdata == 32'h0000_0000)
        else $error("host read data outside its cycle");
    AST_LAUNCH: assert property (
        take && instr.op == OP_OSC && instr.rate[1:0] == OSC_LAUNCH
        |=> readout_launch)
        else $error("readout launch missing");
endmodule : rt_ops_checker

// File: pio_equipment.sv
// Far-side equipment: drives the parallel bus and trigger inputs.
// Assumes callers enter its task right after a rising clock edge.
`timescale 1ns/1ps
module pio_equipment (
    // Clock
    input  wire logic   clock,
    // Lines towards the unit
    output logic [31:0] bus_in,
    output logic [1:0]  trig_in
);
    // Lines idle low until the bench asks for traffic
    initial begin
        bus_in  = 32'h0000_0000;
        trig_in = 2'h0;
    end

    // New word and trigger levels, held at least one full clock
    task automatic drive(input logic [31:0] v, input logic [1:0] t);
        bus_in  <= v;
        trig_in <= t;
        @(posedge clock);
    endtask : drive
endmodule : pio_equipment

// File: readout_sequencer_runtime_ops_test.sv
// Self-checking bench for the run-time operation unit.
// Assumes the package op codes and the equipment model beside it.
`timescale 1ns/1ps
module readout_sequencer_runtime_ops_test
    import rt_ops_pkg::*;
;
    // Design connections
    logic        clock, reset, clk_en, instr_valid, instr_ready;
    logic        strobe_rising, host_wr, host_rd, launch, busy, cond;
    logic [31:0] bus_in, bus_out, host_wdata, host_rdata, v;
    logic [4:0]  strobe_index;
    logic [3:0]  host_addr;
    logic [1:0]  trig_out, trig_in;
    instr_s      instr;
    osc_cmd_s    osc_cmd;
    int          mismatches, compares;
    int          wt[4] = '{0, 1, 3, 40};
    int          sn[4] = '{20, 32, 33, 100};

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    readout_sequencer_runtime_ops readout_sequencer_runtime_ops_inst (
        .clock, .reset, .clk_en, .instr, .instr_valid, .instr_ready,
        .parallel_io_bus_in(bus_in), .parallel_io_bus_out(bus_out),
        .strobe_index, .strobe_rising, .trig_out, .trig_in, .host_addr,
        .host_wdata, .host_wr, .host_rd, .host_rdata, .osc_cmd,
        .readout_launch(launch), .spacing_busy(busy), .cond_true(cond));

    pio_equipment pio_equipment_inst (.clock, .bus_in, .trig_in);

    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Offer one instruction until taken; returns one edge after taking
    task automatic op(input op_e o, input int d, s, u, l, r,
                      input logic [31:0] i, j = 32'h0000_0000);
        int n;
        n = 0;
        instr       <= '{o, 4'(d), 4'(s), 1'(u), 4'(l), 4'(r), i, j};
        instr_valid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (instr_ready !== 1'b1 && n < 300);
        instr_valid <= 1'b0;
        if (n >= 300) begin
            mismatches++;
            stop_test();
        end
        @(posedge clock);
    endtask : op

    // Cycles a stall (ready low) or spacing (busy high) stays up
    task automatic meas(input string nm, input bit sp, input int exp);
        int n;
        n = 0;
        while ((sp ? busy : !instr_ready) === 1'b1 && n < 500) begin
            n++;
            @(posedge clock);
        end
        if (n >= 500) begin
            mismatches++;
            stop_test();
        end
        chk(nm, n, exp);
    endtask : meas

    task automatic host(input bit rd, input logic [3:0] a,
                        input logic [31:0] d);
        host_addr  <= a;
        host_wdata <= d;
        host_rd    <= rd;
        host_wr    <= !rd;
        @(posedge clock);
        {host_rd, host_wr} <= 2'h0;
        @(posedge clock);
        v = host_rdata;
    endtask : host

    // Clock counts rounded up to whole 20 ns cycles
    function automatic int wait_cyc(input int n);
        int c;
        c = (n + WAIT_OVERHEAD < WAIT_MIN_CYC) ? WAIT_MIN_CYC
                                                : n + WAIT_OVERHEAD;
        return (c * SEQ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : wait_cyc

    function automatic int space_cyc(input int n, r);
        int s;
        s = (n < ZERO_MIN_SAMP) ? ZERO_MIN_SAMP : n;
        s = (s + ZERO_STEP_SAMP - 1) / ZERO_STEP_SAMP * ZERO_STEP_SAMP;
        return ((s << r) + SAMP_PER_CLK - 1) / SAMP_PER_CLK;
    endfunction : space_cyc

    initial begin
        {reset, clk_en, strobe_rising} = 3'h7;
        {instr_valid, host_wr, host_rd} = 3'h0;
        instr = '0;
        strobe_index = 5'h03;
        host_addr = 4'h0;
        host_wdata = 32'h0000_0000;
        mismatches = 0;
        compares = 0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // Add and subtract, then variable and constant port writes
        op(OP_LOAD, 1, 1, 1, 0, 0, 32'h0000_0005);
        op(OP_ADD, 1, 1, 1, 0, 0, 32'h0000_0010);
        op(OP_SUB, 1, 1, 1, 0, 0, 32'h0000_0003);
        op(OP_PIO_WR, 0, 1, 0, 0, 0, 32'h0000_0000);
        chk("bus_out", bus_out, 32'h0000_0012);
        op(OP_PIO_WR, 0, 0, 1, 0, 0, 32'hA5A5_5A5A);
        chk("bus_out", bus_out, 32'hA5A5_5A5A);
        op(OP_LOAD, 8, 8, 1, 0, 0, 32'h0000_0000);
        chk("cond_true", cond, 1'h0);
        op(OP_LOAD, 8, 8, 1, 0, 0, 32'h0000_0100);
        chk("cond_true", cond, 1'h1);
        for (int k = 0; k < 8; k++) begin
            op(OP_TRIG_OUT, 0, 0, 1, 0, 0, 32'h1234_5670 + k);
            chk("trig_out", trig_out, k % 4);
        end
        foreach (wt[k]) begin
            op(OP_WAIT, 0, 0, 1, 0, 0, wt[k]);
            meas("wait", 0, wait_cyc(wt[k]));
        end
        $display("port, trigger and wait test done");
        // Live read into a user register, host write read back by code
        pio_equipment_inst.drive(32'hC3C3_0101, 2'h0);
        op(OP_PIO_RD, 2, 0, 0, 0, 0, 32'h0000_0000);
        op(OP_HREG_WR, 0, 2, 0, 7, 0, 32'h0000_0000);
        host(1'b1, 4'h7, 32'h0000_0000);
        chk("host_rdata", v, 32'hC3C3_0101);
        host(1'b0, 4'h9, 32'h1357_9BDF);
        op(OP_HREG_RD, 3, 0, 0, 9, 0, 32'h0000_0000);
        op(OP_PIO_WR, 0, 3, 0, 0, 0, 32'h0000_0000);
        chk("bus_out", bus_out, 32'h1357_9BDF);
        // Host write with the enable low must not land
        clk_en <= 1'b0;
        host(1'b0, 4'h9, 32'h0000_0000);
        clk_en <= 1'b1;
        host(1'b1, 4'h9, 32'h0000_0000);
        chk("host_rdata", v, 32'h1357_9BDF);
        // Strobe wait, capture at the rising strobe, falling one ignored
        pio_equipment_inst.drive(32'hABCD_0000, 2'h0);
        op(OP_STROBE_WT, 0, 0, 0, 0, 0, 32'h0000_0000);
        chk("instr_ready", instr_ready, 1'h0);
        pio_equipment_inst.drive(32'hABCD_0008, 2'h0);
        pio_equipment_inst.drive(32'hABCD_0008, 2'h0);
        pio_equipment_inst.drive(32'h1111_0000, 2'h0);
        op(OP_PIO_LRD, 4, 0, 0, 0, 0, 32'h0000_0000);
        op(OP_PIO_WR, 0, 4, 0, 0, 0, 32'h0000_0000);
        chk("bus_out", bus_out, 32'hABCD_0008);
        // Falling slope: rising strobe ignored, falling one captured
        strobe_rising <= 1'b0;
        pio_equipment_inst.drive(32'h2222_0008, 2'h0);
        op(OP_STROBE_WT, 0, 0, 0, 0, 0, 32'h0000_0000);
        chk("instr_ready", instr_ready, 1'h0);
        pio_equipment_inst.drive(32'h3333_0000, 2'h0);
        op(OP_PIO_LRD, 4, 0, 0, 0, 0, 32'h0000_0000);
        op(OP_PIO_WR, 0, 4, 0, 0, 0, 32'h0000_0000);
        chk("bus_out", bus_out, 32'h3333_0000);
        // Poll both trigger inputs, then wait for input 1
        pio_equipment_inst.drive(32'h0000_0000, 2'h2);
        for (int k = 1; k < 3; k++) begin
            op(OP_TIN_POLL, 5, 0, 0, k, 0, 32'h0000_0000);
            op(OP_PIO_WR, 0, 5, 0, 0, 0, 32'h0000_0000);
            chk("poll", bus_out, k - 1);
        end
        op(OP_TIN_WAIT, 0, 0, 0, 1, 0, 32'h0000_0000);
        chk("instr_ready", instr_ready, 1'h0);
        pio_equipment_inst.drive(32'h0000_0000, 2'h3);
        $display("host, latch and trigger input test done");
        // Spacing lengths, launch beside a running spacing, refusal
        foreach (sn[k]) begin
            op(OP_SPACING, 0, 0, 1, 0, k % 3, sn[k]);
            meas("spacing", 1, space_cyc(sn[k], k % 3));
        end
        op(OP_SPACING, 0, 0, 1, 0, 1, 32'h0000_0064);
        op(OP_OSC, 0, 0, 1, 0, OSC_LAUNCH, 32'h0000_0000);
        chk("readout_launch", launch, 1'h1);
        chk("spacing_busy", busy, 1'h1);
        instr.op    <= OP_SPACING;
        instr_valid <= 1'b1;
        @(posedge clock);
        chk("instr_ready", instr_ready, 1'h0);
        op(OP_SPACING, 0, 0, 1, 0, 0, 32'h0000_0020);
        // Sweep setup, step from a variable, phase zero
        op(OP_OSC, 0, 0, 1, 2, OSC_SWEEP_SETUP, 32'h0001_86A0, 32'h0000_03E8);
        chk("setup", osc_cmd.setup, 1'h1);
        chk("osc", osc_cmd.osc, 4'h2);
        chk("start_hz", osc_cmd.start_hz, 32'h0001_86A0);
        chk("inc_hz", osc_cmd.inc_hz, 32'h0000_03E8);
        op(OP_LOAD, 7, 7, 1, 0, 0, 32'h0000_0005);
        op(OP_OSC, 0, 7, 0, 2, OSC_SWEEP_STEP, 32'h0000_0000);
        chk("index", osc_cmd.index, 32'h0000_0005);
        chk("step", osc_cmd.step, 1'h1);
        op(OP_OSC, 0, 0, 1, 2, OSC_PHASE_ZERO, 32'h0000_0000);
        chk("phase_zero", osc_cmd.phase_zero, 1'h1);
        $display("spacing and oscillator test done");
        stop_test();
    end
endmodule : readout_sequencer_runtime_ops_test

bind readout_sequencer_runtime_ops rt_ops_checker rt_ops_checker_inst (
    .clock, .reset, .clk_en, .instr, .instr_valid, .instr_ready,
    .parallel_io_bus_out, .trig_out, .host_rd, .host_rdata,
    .readout_launch, .spacing_busy);
